//--- aprv_regs.sv
// The implementer's own choices: the Avalon-MM slave port and the address map.
module aprv_regs
	import aprv_pkg::*;
#(
	parameter int NPAIR = PAIRS,
	parameter int NPIN = PINS
) (
	input wire logic CLK,
	input wire logic RST_N,
	input wire logic [ADDR_W-1:0] AVS_ADDRESS,
	input wire logic AVS_READ,
	input wire logic AVS_WRITE,
	input wire logic [31:0] AVS_WRITEDATA,
	input wire logic [3:0] AVS_BYTEENABLE,
	output logic [31:0] AVS_READDATA,
	output logic AVS_WAITREQUEST,
	input wire logic [NPAIR-1:0] PAIR_DATA_READY,
	output logic [NPAIR-1:0] PAIR_DONE_INTERRUPTS,
	output logic [NPIN-1:0] PIN_DIGITAL_MODE,
	output logic [NPIN-1:0] PIN_READ_ENABLE,
	output logic [NPIN-1:0] MUX_TO_ANALOG_GROUND
);
	initial begin
		if (NPAIR != PAIRS || NPIN != PINS) begin
			$error("aprv_regs: pair or pin count unsupported by register layout");
		end
	end

	// ----------------------------------------
	// bus decode
	// ----------------------------------------
	logic [NPAIR-1:0] pair_ready_flag;
	logic [REG_W-1:0] service_table_base;
	logic [NPIN-1:0] pin_mode_bits;
	logic [NPAIR-1:0] ready_prev;
	logic rd_done;
	logic [31:0] rdata;
	logic [NPAIR-1:0] next_ready;
	logic [REG_W-1:0] next_base;
	logic [NPIN-1:0] next_pins;
	logic [REG_W-1:0] enc_term;
	logic [REG_W-1:0] status_view;
	logic [REG_W-1:0] base_view;
	logic [REG_W-1:0] pinsel_view;
	logic [31:0] read_mux;

	wire sel_status = AVS_ADDRESS == OFS_STATUS;
	wire sel_base = AVS_ADDRESS == OFS_BASE;
	wire sel_pinsel = AVS_ADDRESS == OFS_PINSEL;
	wire wr_lo = AVS_WRITE && AVS_BYTEENABLE[0];
	wire wr_hi = AVS_WRITE && AVS_BYTEENABLE[1];

	function automatic logic [REG_W-1:0] merge16(input logic [REG_W-1:0] old, input logic [31:0] wd,
		input logic lo, input logic hi);
		merge16 = {hi ? wd[15:8] : old[15:8], lo ? wd[7:0] : old[7:0]};
	endfunction

	// writes complete at once; reads wait one cycle for registered data
	assign AVS_WAITREQUEST = AVS_READ && !rd_done;

	// ----------------------------------------
	// ready flags
	// ----------------------------------------
	generate
		for (genvar p = 0; p < NPAIR; p++) begin : g_flag
			wire clr = sel_status && wr_lo && !AVS_WRITEDATA[p]; // see (RULE2)
			// a new result in the clearing cycle keeps the flag set
			assign next_ready[p] = PAIR_DATA_READY[p] | (pair_ready_flag[p] & ~clr); // see (RULE1)
		end
	endgenerate

	assign next_base = (sel_base && AVS_WRITE) ?
		(merge16(service_table_base, AVS_WRITEDATA, wr_lo, wr_hi) & BASE_MASK) : service_table_base; // see (RULE4)
	assign next_pins = (sel_pinsel && AVS_WRITE) ?
		NPIN'(merge16(REG_W'(pin_mode_bits), AVS_WRITEDATA, wr_lo, wr_hi) & PINSEL_MASK) : pin_mode_bits;

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			pair_ready_flag <= READY_RST;
			service_table_base <= BASE_RST;
			pin_mode_bits <= NPIN'(PINSEL_RST);
			ready_prev <= READY_RST;
		end else begin
			pair_ready_flag <= next_ready;
			service_table_base <= next_base;
			pin_mode_bits <= next_pins;
			ready_prev <= pair_ready_flag;
		end
	end

	// ----------------------------------------
	// vector encoder and read path
	// ----------------------------------------
	aprv_prio_enc #(.N(NPAIR)) u_enc (
		.req(pair_ready_flag),
		.term(enc_term)
	);

	assign status_view = REG_W'(pair_ready_flag) & STATUS_MASK; // see (RULE3)
	assign base_view = (service_table_base + enc_term) & BASE_MASK; // see (RULE5) see (RULE3)
	assign pinsel_view = REG_W'(pin_mode_bits) & PINSEL_MASK; // see (RULE3)
	assign read_mux = sel_status ? {16'h0000, status_view} :
		sel_base ? {16'h0000, base_view} :
		sel_pinsel ? {16'h0000, pinsel_view} : UNMAPPED_DATA;

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			rd_done <= 1'b0;
			rdata <= 32'h00000000;
		end else begin
			rd_done <= AVS_READ && !rd_done;
			rdata <= read_mux;
		end
	end

	assign AVS_READDATA = rdata;

	// ----------------------------------------
	// pin mode and pair interrupts
	// ----------------------------------------
	assign PIN_DIGITAL_MODE = pin_mode_bits; // see (RULE8) see (RULE9)
	assign PIN_READ_ENABLE = pin_mode_bits; // see (RULE8) see (RULE9)
	assign MUX_TO_ANALOG_GROUND = pin_mode_bits; // see (RULE8)
	// one-cycle pulse when a pair flag rises
	assign PAIR_DONE_INTERRUPTS = pair_ready_flag & ~ready_prev; // see (RULE10)

	// ----------------------------------------
	// checks
	// ----------------------------------------
	chk_flag_set: assert property (@(posedge CLK) disable iff (!RST_N) // see (RULE1)
		PAIR_DATA_READY[0] |=> pair_ready_flag[0]) else $error("ready flag not set");
	chk_flag_clear: assert property (@(posedge CLK) disable iff (!RST_N) // see (RULE2)
		(sel_status && wr_lo && !AVS_WRITEDATA[1] && !PAIR_DATA_READY[1]) |=> !pair_ready_flag[1])
		else $error("ready flag not cleared");
	chk_flag_hold: assert property (@(posedge CLK) disable iff (!RST_N) // see (RULE2)
		(!$past(PAIR_DATA_READY[2]) && !$past(pair_ready_flag[2])) |-> !pair_ready_flag[2])
		else $error("ready flag set without cause");
	chk_unimpl_zero: assert property (@(posedge CLK) disable iff (!RST_N) // see (RULE3)
		(rd_done && !$past(sel_base) && !$past(sel_status) && $past(sel_pinsel)) |-> rdata[31:12] == 20'h00000)
		else $error("unimplemented bits nonzero");
	chk_base_bit0: assert property (@(posedge CLK) disable iff (!RST_N) // see (RULE4)
		service_table_base[0] == 1'b0) else $error("base bit 0 set");
	chk_vector_sum: assert property (@(posedge CLK) disable iff (!RST_N) // see (RULE5)
		(pair_ready_flag[0] && sel_base) |-> base_view == (service_table_base & BASE_MASK))
		else $error("pair 0 vector wrong");
	chk_prio_low: assert property (@(posedge CLK) disable iff (!RST_N) // see (RULE6)
		(pair_ready_flag == 6'h30) |-> enc_term == 16'h0010) else $error("priority wrong");
	chk_no_flag: assert property (@(posedge CLK) disable iff (!RST_N) // see (RULE11)
		(pair_ready_flag == 6'h00) |-> enc_term == 16'h0000) else $error("empty encode nonzero");
	chk_read_wait: assert property (@(posedge CLK) disable iff (!RST_N)
		(AVS_READ && !rd_done) |-> AVS_WAITREQUEST ##1 (rd_done && !AVS_WAITREQUEST))
		else $error("read latency wrong");
	chk_irq_pulse: assert property (@(posedge CLK) disable iff (!RST_N) // see (RULE10)
		(PAIR_DATA_READY[3] && !pair_ready_flag[3]) |=> PAIR_DONE_INTERRUPTS[3] ##1 !PAIR_DONE_INTERRUPTS[3])
		else $error("pair interrupt pulse wrong");
endmodule

//--- aprv_pkg.sv
// Summary of operation
// (RULE1) six hardware-set pair ready flags sit at status bits 5 down to 0
// (RULE2) writing zero to a ready flag clears it; only hardware sets flags
// (RULE3) unimplemented bits read zero: status 15-6, base bit 0, config 15-12
// (RULE4) base bits 15-1 hold software jump-table start, zero after reset
// (RULE5) base read returns stored base plus encoded ready value
// (RULE6) encoder picks lowest-numbered set flag; pair 0 highest priority
// (RULE7) encoded index shifted left two bits before addition
// (RULE8) config bit one: digital mode, read input on, mux to analog ground
// (RULE9) config bit zero, reset state: analog mode, read input off, pin sampled
// (RULE10) each pair raises its own conversion-complete interrupt
// (RULE11) no flag set: encoded term zero, base read returns stored value
package aprv_pkg;
	localparam int REG_W = 16;
	localparam int PAIRS = 6;
	localparam int PINS = 12;
	localparam int ADDR_W = 4;
	// ----------------------------------------
	// register byte offsets
	// ----------------------------------------
	localparam logic [ADDR_W-1:0] OFS_STATUS = 4'h0;
	localparam logic [ADDR_W-1:0] OFS_BASE = 4'h4;
	localparam logic [ADDR_W-1:0] OFS_PINSEL = 4'h8;
	// ----------------------------------------
	// field layout and reset values
	// ----------------------------------------
	localparam logic [REG_W-1:0] STATUS_MASK = 16'h003F;
	localparam logic [REG_W-1:0] BASE_MASK = 16'hFFFE;
	localparam logic [REG_W-1:0] PINSEL_MASK = 16'h0FFF;
	localparam logic [REG_W-1:0] BASE_RST = 16'h0000;
	localparam logic [REG_W-1:0] PINSEL_RST = 16'h0000;
	localparam logic [PAIRS-1:0] READY_RST = 6'h00;
	localparam int ENC_SHIFT = 2;
	localparam logic [31:0] UNMAPPED_DATA = 32'h00000000;
endpackage

//--- aprv_prio_enc.sv
module aprv_prio_enc
	import aprv_pkg::*;
#(
	parameter int N = PAIRS
) (
	input wire logic [N-1:0] req,
	output logic [REG_W-1:0] term
);
	initial begin
		if (N < 1 || N > 16) begin
			$error("aprv_prio_enc: N out of range");
		end
	end

	logic [REG_W-1:0] idx;

	// lowest set bit wins; loop runs downward so bit 0 is assigned last
	always_comb begin
		idx = '0;
		for (int i = N - 1; i >= 0; i--) begin
			if (req[i]) begin
				idx = REG_W'(i); // see (RULE6)
			end
		end
	end

	assign term = idx << ENC_SHIFT; // see (RULE7) see (RULE11)
endmodule

//--- aprv_regs_tb.sv
module aprv_regs_tb import aprv_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	// ----------------------------------------
	// stimulus and observation signals
	// ----------------------------------------
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [ADDR_W-1:0] addr = '0;
	logic rd = 1'b0;
	logic wr = 1'b0;
	logic [31:0] wdata = '0;
	logic [3:0] be = 4'h3;
	logic [31:0] rdata;
	logic wait_req;
	logic [PAIRS-1:0] rdy = '0;
	logic [PAIRS-1:0] irq;
	logic [PAIRS-1:0] irq_seen = '0;
	logic [PINS-1:0] dig;
	logic [PINS-1:0] ren;
	logic [PINS-1:0] gnd;
	logic [31:0] got;
	int n_errors = 0;
	int n_compared = 0;
	aprv_regs u_dut (.CLK(clk), .RST_N(rst_n), .AVS_ADDRESS(addr), .AVS_READ(rd), .AVS_WRITE(wr),
		.AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(be), .AVS_READDATA(rdata), .AVS_WAITREQUEST(wait_req),
		.PAIR_DATA_READY(rdy), .PAIR_DONE_INTERRUPTS(irq), .PIN_DIGITAL_MODE(dig),
		.PIN_READ_ENABLE(ren), .MUX_TO_ANALOG_GROUND(gnd));
	always #2 clk = ~clk;
	always @(posedge clk) irq_seen <= irq_seen | irq;
	// ----------------------------------------
	// bus tasks and comparison
	// ----------------------------------------
	task automatic bus_access(input logic is_wr, input logic [ADDR_W-1:0] a, input logic [15:0] d);
		addr <= a;
		wdata <= {16'h0000, d};
		rd <= !is_wr;
		wr <= is_wr;
		// values read on resuming at an edge are those that edge samples
		do @(posedge clk); while (wait_req !== 1'b0);
		got = rdata;
		rd <= 1'b0;
		wr <= 1'b0;
		@(posedge clk);
	endtask
	task automatic check(input logic [31:0] g, input logic [31:0] e, input string what);
		n_compared++;
		if (g !== e) begin
			n_errors++;
			$display("FAIL %0t %s got %h expected %h", $time, what, g, e);
		end
	endtask
	task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [15:0] e, input string what);
		bus_access(1'b0, a, 16'h0000);
		check(got, {16'h0000, e}, what);
	endtask
	task automatic pulse(input logic [PAIRS-1:0] m);
		@(posedge clk);
		rdy <= m;
		@(posedge clk);
		rdy <= '0;
	endtask
	task automatic print_verdict;
		if (n_errors == 0 && n_compared > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	// ----------------------------------------
	// tests
	// ----------------------------------------
	initial begin
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		rd_chk(OFS_STATUS, 16'h0000, "status after reset");
		rd_chk(OFS_BASE, 16'h0000, "base after reset");
		rd_chk(OFS_PINSEL, 16'h0000, "pins after reset");
		check({20'h00000, dig | ren | gnd}, 32'h00000000, "analog outputs");
		bus_access(1'b1, OFS_PINSEL, 16'hFFFF);
		rd_chk(OFS_PINSEL, 16'h0FFF, "pin select upper bits");
		bus_access(1'b1, OFS_PINSEL, 16'h0A5A);
		check({8'h00, dig, ren}, 32'h00A5AA5A, "digital mode and read enable");
		check({20'h00000, gnd}, 32'h00000A5A, "mux to ground");
		bus_access(1'b1, OFS_BASE, 16'hFFFF);
		rd_chk(OFS_BASE, 16'hFFFE, "base bit 0");
		bus_access(1'b1, OFS_BASE, 16'h1230);
		rd_chk(OFS_BASE, 16'h1230, "base without flags");
		pulse(6'h3F);
		rd_chk(OFS_STATUS, 16'h003F, "all flags set");
		check({26'h0000000, irq_seen}, 32'h0000003F, "pair interrupts");
		// clear one flag at a time, highest priority first
		for (int i = 0; i < PAIRS; i++) begin
			rd_chk(OFS_BASE, 16'h1230 + 16'(4 * i), "vectored base");
			bus_access(1'b1, OFS_STATUS, ~(16'h0001 << i));
			rd_chk(OFS_STATUS, (16'h003F << (i + 1)) & 16'h003F, "flag cleared");
		end
		rd_chk(OFS_BASE, 16'h1230, "base after clearing");
		bus_access(1'b1, OFS_BASE, 16'hFFFE);
		pulse(6'h20);
		rd_chk(OFS_BASE, 16'h0012, "lowest pair with wrap");
		bus_access(1'b1, 4'hC, 16'h0000);
		rd_chk(4'hC, 16'h0000, "unmapped read");
		rd_chk(OFS_STATUS, 16'h0020, "flag kept");
		print_verdict;
	end
	initial begin
		#40000;
		n_errors++;
		print_verdict;
	end
endmodule
